// *** core/ioccr_core.sv ***
`timescale 1ns/1ps
`include "ioccr_regs.svh"
module ioccr_core #(
   parameter int NDEV = 2,
   parameter logic [3:0] CMD_COUNT = `IOCCR_CMD_COUNT,
   parameter int RECOV_CYC = `IOCCR_RECOV_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Command from channel
   input wire logic cmdValid,
   input wire logic [7:0] cmdDevAddr,
   input wire logic [3:0] cmdCode,
   input wire logic [3:0] cmdModifier,
   input wire logic [15:0] cmdDcbAddr,
   input wire logic cmdParityErr,
   input wire logic cmdIntNeeded,
   output logic cmdAck,
   output ioccr_pkg::ioccr_cc_t cmdCc,
   output logic dcbFetch,
   output logic devBusy,
   // Controller and operation events
   input wire logic ctlOccupied,
   input wire logic pciDone,
   input wire logic [7:0] dcbId,
   input wire logic opDone,
   input wire logic opExc,
   input wire logic [7:0] excStatus,
   input wire logic suppHit,
   input wire logic attnEvt,
   input wire logic [7:0] attnInfo,
   // Interrupt presentation
   output logic intReq,
   input wire logic intAck,
   output logic intDone,
   output ioccr_pkg::ioccr_cc_t intCc,
   output logic [15:0] intId
);
   ////////////////////////////////////////////////////////////////////////////
   ioccr_pkg::ioccr_state_t state_q;
   logic [11:0] recovCnt_q;
   logic [3:0] ctrl_q;
   logic [7:0] base_q;
   logic wrPend_q;
   logic [7:0] wrAddr_q;
   logic ctlEndPend_q;
   logic attn_q;
   logic pci_q;
   logic exc_q;
   logic end_q;
   logic perm_q;
   logic suppSeen_q;
   logic [7:0] isb_q;
   logic [7:0] pciId_q;
   logic [7:0] attnInfo_q;
   ioccr_pkg::ioccr_cc_t ccNext;
   ioccr_pkg::ioccr_cc_t devCode;
   logic accept;
   logic devPend;
   logic ctlEndReady;
   logic takeDev;
   logic takeCtl;
   logic devEvt;
   logic [7:0] devInfo;
   logic rdTake;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus decode helpers
   function automatic logic [31:0] regRead(input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (a == `IOCCR_CTRL_OFS) begin
         v = {28'h0000000, ctrl_q};
      end else if (a == `IOCCR_BASE_OFS) begin
         v = {24'h000000, base_q};
      end else if (a == `IOCCR_STAT_OFS) begin
         v = {24'h000000, isb_q} << 8;
         v[0] = (state_q == ioccr_pkg::ST_RECOVER);
         v[1] = (state_q == ioccr_pkg::ST_BUSY);
         v[2] = ctlEndPend_q;
         v[3] = intReq;
         v[4] = attn_q;
         v[5] = pci_q;
         v[6] = exc_q;
         v[7] = end_q;
         v[16] = suppSeen_q;
      end else if (a == `IOCCR_LAST_OFS) begin
         v = {intId, 5'h00, intCc, 5'h00, cmdCc};
      end
      return v;
   endfunction

   // Function and modifier pairing: only the start command takes a modifier
   function automatic logic legalPair(input logic [3:0] c, input logic [3:0] m);
      return (m == 4'h0) || (c == `IOCCR_CMD_START);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rdTake = hsel && hready && htrans[1] && !hwrite;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end else begin
         wrPend_q <= hsel && hready && htrans[1] && hwrite;
         wrAddr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rdTake) begin
         hrdata <= (haddr[31:8] == 24'h000000) ? regRead(haddr[7:0]) : 32'h0000_0000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= `IOCCR_CTRL_RST;
         base_q <= `IOCCR_BASE_RST;
      end else if (wrPend_q) begin
         if (wrAddr_q == `IOCCR_CTRL_OFS) begin
            ctrl_q <= hwdata[3:0];
         end else if (wrAddr_q == `IOCCR_BASE_OFS) begin
            base_q <= hwdata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Immediate condition code, one value per command
   always_comb begin
      logic [7:0] ofs;
      ofs = cmdDevAddr - base_q;
      if (32'(ofs) >= NDEV) begin
         ccNext = 3'h0;
      end else if (NDEV >= 2 && ctlOccupied) begin
         ccNext = 3'h6;
      end else if (ofs != 8'h00) begin
         ccNext = 3'h0;
      end else if (state_q == ioccr_pkg::ST_RECOVER) begin
         ccNext = 3'h2;
      end else if (state_q == ioccr_pkg::ST_BUSY) begin
         ccNext = 3'h1;
      end else if (ctrl_q[`IOCCR_CTRL_INTERV]) begin
         ccNext = 3'h4;
      end else if (cmdParityErr) begin
         ccNext = 3'h5;
      end else if (cmdCode >= CMD_COUNT || ctrl_q[`IOCCR_CTRL_NRDY] ||
                   cmdDcbAddr[0] || !legalPair(cmdCode, cmdModifier)) begin
         ccNext = 3'h3;
      end else begin
         ccNext = 3'h7;
      end
   end

   assign accept = cmdValid && (ccNext == 3'h7);

   // Code and acknowledge leave together from flops
   // Bit 2 feeds even, bit 0 overflow of the status register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmdAck <= 1'b0;
         cmdCc <= 3'h0;
      end else begin
         cmdAck <= cmdValid;
         if (cmdValid) begin
            cmdCc <= ccNext;
         end
      end
   end

   // Fetch only after acceptance, never on reject
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dcbFetch <= 1'b0;
      end else begin
         dcbFetch <= accept && ctrl_q[`IOCCR_CTRL_CSTEAL] && (cmdCode == `IOCCR_CMD_START);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset recovery and busy tracking
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         recovCnt_q <= 12'(RECOV_CYC);
      end else if (recovCnt_q != 12'h000) begin
         recovCnt_q <= recovCnt_q - 12'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= ioccr_pkg::ST_RECOVER;
      end else begin
         case (state_q)
            ioccr_pkg::ST_RECOVER: begin
               // Leaves silently, no interrupt is queued
               if (recovCnt_q == 12'h000) begin
                  state_q <= ioccr_pkg::ST_READY;
               end
            end
            ioccr_pkg::ST_READY: begin
               if (accept && cmdIntNeeded) begin
                  state_q <= ioccr_pkg::ST_BUSY;
               end
            end
            ioccr_pkg::ST_BUSY: begin
               if (takeDev) begin
                  state_q <= ioccr_pkg::ST_READY;
               end
            end
            default: begin
               state_q <= ioccr_pkg::ST_READY;
            end
         endcase
      end
   end

   assign devBusy = (state_q == ioccr_pkg::ST_BUSY);

   ////////////////////////////////////////////////////////////////////////////
   // Controller end after a busy answer; set wins over clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctlEndPend_q <= 1'b0;
      end else if (cmdValid && ccNext == 3'h6) begin
         ctlEndPend_q <= 1'b1;
      end else if (takeCtl) begin
         ctlEndPend_q <= 1'b0;
      end
   end

   assign ctlEndReady = ctlEndPend_q && !ctlOccupied;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky interrupt conditions; a new event in the ack cycle survives
   assign devEvt = opDone || opExc;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         attn_q <= 1'b0;
         attnInfo_q <= 8'h00;
      end else if (attnEvt) begin
         attn_q <= 1'b1;
         attnInfo_q <= attnInfo;
      end else if (takeDev) begin
         attn_q <= 1'b0;
      end
   end

   // Pending program request is dropped when a newer end arrives
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pci_q <= 1'b0;
         pciId_q <= 8'h00;
      end else if (pciDone) begin
         pci_q <= 1'b1;
         pciId_q <= dcbId;
      end else if (devEvt || takeDev) begin
         pci_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         exc_q <= 1'b0;
         isb_q <= 8'h00;
      end else if (opExc) begin
         exc_q <= 1'b1;
         isb_q <= excStatus;
      end else if (takeDev) begin
         exc_q <= 1'b0;
         isb_q <= 8'h00;
      end
   end

   // Normal end; permissive when a suppressed exception was seen
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         end_q <= 1'b0;
         perm_q <= 1'b0;
      end else if (opDone && !opExc) begin
         end_q <= 1'b1;
         perm_q <= ctrl_q[`IOCCR_CTRL_SUPP] && (suppSeen_q || suppHit);
      end else if (takeDev) begin
         end_q <= 1'b0;
         perm_q <= 1'b0;
      end
   end

   // Suppression history restarts at each accepted start command
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         suppSeen_q <= 1'b0;
      end else if (suppHit) begin
         suppSeen_q <= 1'b1;
      end else if (accept && cmdCode == `IOCCR_CMD_START) begin
         suppSeen_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Presentation: one code per acknowledge
   ioccr_icc_encode u_enc (
      .attention(attn_q),
      .pci(pci_q && !exc_q),
      .exception(exc_q),
      .devEnd(end_q),
      .code(devCode)
   );

   assign devPend = attn_q || pci_q || exc_q || end_q;
   // Controller busy answer 6 always leads to a later controller end interrupt
   assign intReq = devPend || ctlEndReady;
   assign takeDev = intAck && devPend;
   assign takeCtl = intAck && !devPend && ctlEndReady;

   always_comb begin
      if (exc_q) begin
         devInfo = isb_q;
      end else if (pci_q) begin
         devInfo = pciId_q;
      end else if (end_q) begin
         devInfo = {perm_q, 7'h00};
      end else begin
         devInfo = attnInfo_q;
      end
   end

   // Info in upper byte, device address in lower byte
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         intDone <= 1'b0;
         intCc <= 3'h0;
         intId <= 16'h0000;
      end else begin
         intDone <= takeDev || takeCtl;
         if (takeDev) begin
            intCc <= devCode;
            intId <= {devInfo, base_q};
         end else if (takeCtl) begin
            intCc <= 3'h0;
            intId <= {8'h00, base_q};
         end
      end
   end
endmodule // ioccr_core

// *** common/ioccr_regs.svh ***
// Behaviour
// - Every command gets exactly one of eight condition codes at once
// - Condition codes are 3-bit values 0 to 7 kept in level status register
// - Unit not present on the system answers code 0
// - Command needing an interrupt makes device busy until acknowledge; busy answers 1
// - After busy code a later interrupt from the same address follows
// - Recovering from reset answers 2; no interrupt when recovery ends
// - Unknown command, forbidden state or bad parameter answers 3
// - A rejected command never fetches its device control block
// - Condition needing operator action answers 4
// - Receiver seeing bus parity error answers 5
// - Controller of two or more devices answers 6 while occupied
// - Accepted command answers 7
// - Acknowledge supplies interrupt code plus ID word, info in upper byte
// - Controller end interrupts code 0, lowest group address, info zero
// - Error-free transfer of block with program-interrupt bit interrupts 1
// - Error or exception interrupts code 2 with status byte
// - Normal end without error, attention or program request interrupts 3
// - Normal end after suppressed exception sets info byte bit 7
// - External event interrupts code 4
// - Attention combines: 5 with program request, 6 exception, 7 device end
// - Exactly one interrupt code per interrupt; exception outranks program request and end
// - Lower ID byte carries interrupting device address
// - Interrupt status byte cleared once the interrupt is accepted
`ifndef IOCCR_REGS_SVH
`define IOCCR_REGS_SVH

`define IOCCR_CTRL_OFS 8'h00
`define IOCCR_BASE_OFS 8'h04
`define IOCCR_STAT_OFS 8'h08
`define IOCCR_LAST_OFS 8'h0C

`define IOCCR_CTRL_INTERV 0
`define IOCCR_CTRL_NRDY 1
`define IOCCR_CTRL_SUPP 2
`define IOCCR_CTRL_CSTEAL 3
`define IOCCR_CTRL_RST 4'h0
`define IOCCR_BASE_RST 8'h00

`define IOCCR_CMD_START 4'h1
`define IOCCR_CMD_COUNT 4'h8

`define IOCCR_CLK_MHZ 250
`define IOCCR_RECOV_NS 2000
`define IOCCR_RECOV_CYC ((`IOCCR_RECOV_NS * `IOCCR_CLK_MHZ + 999) / 1000)

`endif

// *** common/ioccr_pkg.sv ***
package ioccr_pkg;
   typedef logic [2:0] ioccr_cc_t;
   typedef enum logic [1:0] {ST_RECOVER, ST_READY, ST_BUSY} ioccr_state_t;
endpackage

// *** core/ioccr_icc_encode.sv ***
`timescale 1ns/1ps
module ioccr_icc_encode (
   // Pending conditions
   input wire logic attention,
   input wire logic pci,
   input wire logic exception,
   input wire logic devEnd,
   // Single code
   output ioccr_pkg::ioccr_cc_t code
);
   logic [1:0] low;

   // Exception outranks program request and end, so one code results
   always_comb begin
      if (exception) begin
         low = 2'h2;
      end else if (pci) begin
         low = 2'h1;
      end else if (devEnd) begin
         low = 2'h3;
      end else begin
         low = 2'h0;
      end
   end

   assign code = {attention, low};
endmodule // ioccr_icc_encode

// *** dv/ioccr_props.sv ***
`timescale 1ns/1ps
module ioccr_props #(
   parameter int NDEV = 2,
   parameter logic [3:0] CMD_COUNT = 4'h8,
   parameter int RECOV_CYC = 500
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Command side
   input wire logic cmdValid,
   input wire logic [15:0] cmdDcbAddr,
   input wire logic cmdParityErr,
   input wire logic cmdAck,
   input wire ioccr_pkg::ioccr_cc_t cmdCc,
   input wire logic dcbFetch,
   input wire logic devBusy,
   input wire logic ctlOccupied,
   // Interrupt side
   input wire logic intReq,
   input wire logic intAck,
   input wire logic intDone,
   input wire ioccr_pkg::ioccr_cc_t intCc,
   input wire logic [15:0] intId
);
   int sinceRst_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // Saturates so a long run cannot wrap back into recovery
   always_ff @(posedge ref_clk) begin
      if (rst) sinceRst_q <= 0;
      else if (sinceRst_q < 100000) sinceRst_q <= sinceRst_q + 1;
   end
   ////////////////////////////////////////////////////////////////
   cmd_ack_a: assert property (cmdValid |=> cmdAck)
      else $error("command not answered next cycle");
   lone_ack_a: assert property (cmdAck |-> $past(cmdValid))
      else $error("answer without command");
   recov_code_a: assert property (cmdValid && sinceRst_q < RECOV_CYC - 1
      |=> cmdCc inside {3'h0, 3'h2, 3'h6}) else $error("recovery code wrong");
   busy_code_a: assert property (cmdValid && devBusy && !ctlOccupied
      |=> cmdCc inside {3'h0, 3'h1}) else $error("busy code wrong");
   ctl_busy_a: assert property (cmdValid && ctlOccupied |=> cmdCc inside {3'h0, 3'h6})
      else $error("controller busy code wrong");
   parity_code_a: assert property (cmdValid && cmdParityErr |=> cmdCc != 3'h7)
      else $error("parity error accepted");
   odd_dcb_a: assert property (cmdValid && cmdDcbAddr[0] |=> cmdCc != 3'h7)
      else $error("odd block address accepted");
   fetch_ok_a: assert property (dcbFetch |-> cmdAck && cmdCc == 3'h7)
      else $error("block fetched on reject");
   int_done_a: assert property (intAck && intReq |=> intDone)
      else $error("acknowledge not answered");
   ctl_end_a: assert property (intDone && intCc == 3'h0 |-> intId[15:8] == 8'h00)
      else $error("controller end info not zero");
   end_info_a: assert property (intDone && intCc[1:0] == 2'h3 |-> intId[14:8] == 7'h00)
      else $error("device end info wrong");
   busy_exit_a: assert property ($fell(devBusy) |-> intDone)
      else $error("busy left without acceptance");
endmodule // ioccr_props

bind ioccr_core ioccr_props #(.NDEV(NDEV), .CMD_COUNT(CMD_COUNT), .RECOV_CYC(RECOV_CYC))
   ioccr_props_i (.ref_clk, .rst, .cmdValid, .cmdDcbAddr, .cmdParityErr, .cmdAck, .cmdCc,
   .dcbFetch, .devBusy, .ctlOccupied, .intReq, .intAck, .intDone, .intCc, .intId);

// *** dv/ioccr_cpu_model.sv ***
`timescale 1ns/1ps
module ioccr_cpu_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Pacing
   input wire logic slow,
   // Interrupt handshake
   input wire logic intReq,
   output logic intAck,
   input wire logic intDone,
   input wire ioccr_pkg::ioccr_cc_t intCc,
   input wire logic [15:0] intId,
   // Captured level status
   output logic [2:0] lsrFlags,
   output logic [15:0] lastId,
   output int nInt
);
   logic pend_q;
   logic [3:0] wait_q;
   ////////////////////////////////////////////////////////////////
   // Pending flag stops a second acknowledge before the first lands
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         intAck <= 1'b0;
         pend_q <= 1'b0;
         wait_q <= 4'h0;
      end else begin
         intAck <= 1'b0;
         if (intReq && !pend_q) begin
            if (!slow || wait_q == 4'h6) begin
               intAck <= 1'b1;
               pend_q <= 1'b1;
               wait_q <= 4'h0;
            end else wait_q <= wait_q + 4'h1;
         end
         if (intDone) pend_q <= 1'b0;
      end
   end
   // Even takes bit 2, carry bit 1, overflow bit 0
   always_ff @(posedge ref_clk) begin
      if (rst) nInt <= 0;
      else if (intDone) begin
         lsrFlags <= {intCc[2], intCc[1], intCc[0]};
         lastId <= intId;
         nInt <= nInt + 1;
      end
   end
endmodule // ioccr_cpu_model

// *** dv/ioccr_core_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin nErrors++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module ioccr_core_test;
   logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, slow = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2, lsrFlags;
   logic cmdValid = 0, cmdParityErr = 0, cmdIntNeeded = 0, cmdAck, dcbFetch, devBusy;
   logic [7:0] cmdDevAddr = '0, dcbId = '0, excStatus = '0, attnInfo = '0;
   logic [3:0] cmdCode = '0, cmdModifier = '0;
   logic [15:0] cmdDcbAddr = '0, intId, lastId;
   logic ctlOccupied = 0, pciDone = 0, opDone = 0, opExc = 0, suppHit = 0, attnEvt = 0;
   logic intReq, intAck, intDone;
   ioccr_pkg::ioccr_cc_t cmdCc, intCc;
   int nErrors = 0, checks = 0, nInt, cyc = 0;
   ioccr_core #(.RECOV_CYC(8)) ioccr_core_i (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cmdValid, .cmdDevAddr,
      .cmdCode, .cmdModifier, .cmdDcbAddr, .cmdParityErr, .cmdIntNeeded, .cmdAck, .cmdCc,
      .dcbFetch, .devBusy, .ctlOccupied, .pciDone, .dcbId, .opDone, .opExc, .excStatus,
      .suppHit, .attnEvt, .attnInfo, .intReq, .intAck, .intDone, .intCc, .intId);
   ioccr_cpu_model ioccr_cpu_model_i (.ref_clk, .rst, .slow, .intReq, .intAck, .intDone,
      .intCc, .intId, .lsrFlags, .lastId, .nInt);
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks=%0d errors=%0d", checks, nErrors);
      if (nErrors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Slave answers with hready, so both phases wait on it
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata;
      `CHK(hresp, 1'b0)
   endtask
   task automatic cmd(input logic [7:0] a, input logic [3:0] c, m, input logic [15:0] dcb,
         input logic par, need, input logic [2:0] exp);
      @(posedge ref_clk);
      cmdValid <= 1'b1;
      cmdDevAddr <= a;
      cmdCode <= c;
      cmdModifier <= m;
      cmdDcbAddr <= dcb;
      cmdParityErr <= par;
      cmdIntNeeded <= need;
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      cmdDevAddr <= ~a;
      #1 `CHK(cmdAck, 1'b1)
      `CHK(cmdCc, exp)
   endtask
   // Event vector: attention, exception, program request, normal end
   task automatic evt(input logic [3:0] ev, input logic [7:0] info, input logic [2:0] ecc,
         input logic [7:0] eib);
      int n;
      n = nInt;
      @(posedge ref_clk);
      {attnEvt, opExc, pciDone, opDone} <= ev;
      {dcbId, excStatus, attnInfo} <= {3{info}};
      @(posedge ref_clk);
      {attnEvt, opExc, pciDone, opDone} <= 4'h0;
      wait (nInt != n);
      `CHK(lsrFlags, ecc)
      `CHK(lastId, {eib, 8'h20})
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         nErrors++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      cmd(8'h00, 4'h2, 4'h0, 16'h0, 0, 0, 3'h2);
      repeat (12) @(posedge ref_clk);
      `CHK(intReq, 1'b0)
      bus(0, 8'h00, 0);
      `CHK(r, 32'h0)
      bus(1, 8'h04, 32'h20);
      bus(0, 8'h04, 0);
      `CHK(r, 32'h20)
      bus(1, 8'h40, 32'hFF);
      bus(0, 8'h40, 0);
      `CHK(r, 32'h0)
      cmd(8'h50, 4'h2, 4'h0, 16'h0, 0, 0, 3'h0);
      cmd(8'h21, 4'h2, 4'h0, 16'h0, 0, 0, 3'h0);
      @(posedge ref_clk) ctlOccupied <= 1'b1;
      cmd(8'h21, 4'h2, 4'h0, 16'h0, 0, 0, 3'h6);
      @(posedge ref_clk) ctlOccupied <= 1'b0;
      evt(4'h0, 8'h00, 3'h0, 8'h00);
      cmd(8'h20, 4'h9, 4'h0, 16'h0, 0, 0, 3'h3);
      cmd(8'h20, 4'h2, 4'h3, 16'h0, 0, 0, 3'h3);
      cmd(8'h20, 4'h2, 4'h0, 16'h0, 1, 0, 3'h5);
      bus(1, 8'h00, 32'h3);
      cmd(8'h20, 4'h2, 4'h0, 16'h0, 0, 0, 3'h4);
      bus(1, 8'h00, 32'h2);
      cmd(8'h20, 4'h2, 4'h0, 16'h0, 0, 0, 3'h3);
      bus(1, 8'h00, 32'hC);
      cmd(8'h20, 4'h1, 4'h0, 16'h0101, 0, 1, 3'h3);
      `CHK(dcbFetch, 1'b0)
      cmd(8'h20, 4'h1, 4'h0, 16'h0100, 0, 1, 3'h7);
      `CHK(dcbFetch, 1'b1)
      cmd(8'h20, 4'h2, 4'h0, 16'h0, 0, 0, 3'h1);
      evt(4'h2, 8'h5A, 3'h1, 8'h5A);
      `CHK(devBusy, 1'b0)
      slow <= 1'b1;
      evt(4'h1, 8'h00, 3'h3, 8'h00);
      evt(4'h4, 8'h42, 3'h2, 8'h42);
      bus(0, 8'h08, 0);
      `CHK(r[15:8], 8'h00)
      evt(4'h8, 8'h33, 3'h4, 8'h33);
      evt(4'hA, 8'h5B, 3'h5, 8'h5B);
      evt(4'hC, 8'h66, 3'h6, 8'h66);
      evt(4'h9, 8'h00, 3'h7, 8'h00);
      cmd(8'h20, 4'h1, 4'h0, 16'h0100, 0, 1, 3'h7);
      @(posedge ref_clk);
      suppHit <= 1'b1;
      @(posedge ref_clk);
      suppHit <= 1'b0;
      evt(4'h1, 8'h00, 3'h3, 8'h80);
      bus(0, 8'h0C, 0);
      `CHK(r, 32'h80200307)
      final_report();
   end
endmodule // ioccr_core_test
